// ---- src/fpc_regs.svh ----
// Purpose: constants of the flash programming command port
// Assumes: 50 MHz system clock, byte-wide fuse and lock cells
// Notes: both links share one command byte set
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH
`define FPC_PREAMBLE       8'haa
`define FPC_OP_RD_LOCK     8'h64
`define FPC_OP_RD_FUSE     8'h61
`define FPC_OP_RD_STAT     8'h60
`define FPC_OP_WR_FUSE     8'he1
`define FPC_OP_WR_LOCK     8'he4
`define FPC_ADDR_ZERO      8'h00
`define FPC_FUSE_ADDR      1'h0
`define FPC_LOCK_ADDR      1'h1
`define FPC_FUSE_RESET     8'hff
`define FPC_LOCK_RESET     8'hff
`define FPC_SPE_BIT        0
`define FPC_STAT_BUSY_BIT  0
`define FPC_CLK_KHZ        50000
`define FPC_WRITE_WAIT_MS  4
`define FPC_WRITE_WAIT_CYC (`FPC_WRITE_WAIT_MS * `FPC_CLK_KHZ)
`endif

// ---- src/fpc_pkg.sv ----
// Purpose: types of the flash programming command port
// Assumes: constants live in fpc_regs.svh
// Notes: state codes are gray along the command path
`default_nettype none
package fpc_pkg;
  localparam int FPC_CNT_W = 20;

  typedef enum logic [2:0] {
    FPC_IDLE = 3'h0,
    FPC_PRE  = 3'h1,
    FPC_OPC  = 3'h3,
    FPC_ADH  = 3'h2,
    FPC_DATA = 3'h6,
    FPC_DONE = 3'h7,
    FPC_SKIP = 3'h5
  } fpc_state_e;

  typedef struct packed {
    logic       valid;
    logic       serial;
    logic [7:0] data;
  } fpc_byte_s;

  typedef struct packed {
    logic       pending;
    logic       addr;
    logic [7:0] data;
  } fpc_wr_s;

  typedef struct packed {
    logic [6:0] shift;
    logic [7:0] rx;
    logic       tgl;
  } fpc_link_s;

  typedef struct packed {
    logic [2:0]           strobe_sy;
    logic [7:0]           data_s0;
    logic [7:0]           data_s1;
    logic [2:0]           sel_sy;
    logic [2:0]           ss_sy;
    logic [2:0]           tgl_sy;
    fpc_state_e           state;
    logic [7:0]           opcode;
    logic                 ser;
    fpc_wr_s              wr;
    logic                 busy;
    logic [FPC_CNT_W-1:0] busy_cnt;
    logic                 drive;
    logic [7:0]           dout;
    logic [1:0]           boot;
    logic                 spe_eff;
    logic                 p_oe_n;
    logic                 sdout_oe_n;
    logic                 busy_n;
  } fpc_top_s;
endpackage
`default_nettype wire

// ---- src/fpc_fuse_mem.sv ----
// Purpose: nonvolatile fuse and lock byte cells
// Assumes: one write and one read port on clk
// Notes: contents survive reset, as the real cells do
`default_nettype none
`include "fpc_regs.svh"
module fpc_fuse_mem #(
  parameter int unsigned        W     = 8,
  parameter int unsigned        DEPTH = 2,
  parameter logic [DEPTH*W-1:0] INIT  = {`FPC_LOCK_RESET, `FPC_FUSE_RESET}
) (
  input  wire logic                     clk,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [W-1:0]             wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output var  logic [W-1:0]             rd_data
);
  // no reset on purpose: a reset models a power cycle
  logic [DEPTH*W-1:0] mem_q = INIT;

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr*W +: W] <= wr_data;
    end
    rd_data <= mem_q[rd_addr*W +: W];
  end
endmodule
`default_nettype wire

// ---- src/fpc_serial_link.sv ----
// Purpose: serial link shifter on the programmer's clock
// Assumes: serial clock runs only inside a select frame
// Notes: each received byte flips rx_tgl; rx_byte then holds
`default_nettype none
`include "fpc_regs.svh"
module fpc_serial_link (
  input  wire logic       reset,
  input  wire logic       serial_clk,
  input  wire logic       serial_sel_n,
  input  wire logic       serial_din,
  input  wire logic [7:0] tx_byte,
  output var  logic       serial_dout,
  output var  logic [7:0] rx_byte,
  output var  logic       rx_tgl
);
  fpc_pkg::fpc_link_s lk_q;
  fpc_pkg::fpc_link_s lk_d;
  logic [2:0]         cnt_q;

  always_comb begin
    lk_d = lk_q;
    lk_d.shift = {lk_q.shift[5:0], serial_din};
    if (cnt_q == 3'h7) begin
      lk_d.rx = {lk_q.shift, serial_din};
      lk_d.tgl = ~lk_q.tgl;
    end
  end

  // clock may stand still, so reset does not wait for an edge
  always_ff @(posedge serial_clk or posedge reset) begin
    if (reset) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  // frame select realigns the bit count
  always_ff @(posedge serial_clk or posedge serial_sel_n) begin
    if (serial_sel_n) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // tx_byte is settled one byte before it is shifted out
  always_ff @(negedge serial_clk or posedge serial_sel_n) begin
    if (serial_sel_n) begin
      serial_dout <= 1'b0;
    end else begin
      serial_dout <= tx_byte[3'h7 - cnt_q];
    end
  end

  assign rx_byte = lk_q.rx;
  assign rx_tgl  = lk_q.tgl;
endmodule
`default_nettype wire

// ---- src/fpc_top.sv ----
// Purpose: programming-mode command decoder for fuses and lock bits
// Assumes: strobe, select and data pins are asynchronous to clk
// Notes: parallel link wins when both selects are low
`default_nettype none
`include "fpc_regs.svh"
module fpc_top #(
  parameter int unsigned WRITE_WAIT_CYC = `FPC_WRITE_WAIT_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       select_pin_n,
  input  wire logic       byte_strobe_pin,
  input  wire logic [7:0] parallel_data_port_in,
  output var  logic [7:0] parallel_data_port_out,
  output var  logic       parallel_data_port_oe_n,
  output var  logic       busy_indicator_pin_n,
  input  wire logic       serial_clk,
  input  wire logic       serial_sel_n,
  input  wire logic       serial_din,
  output var  logic       serial_dout,
  output var  logic       serial_dout_oe_n
);
  localparam int CW = fpc_pkg::FPC_CNT_W;

  fpc_pkg::fpc_top_s  st_q;
  fpc_pkg::fpc_top_s  st_d;
  fpc_pkg::fpc_byte_s ev;
  logic [7:0]         rx_byte;
  logic               rx_tgl;
  logic [7:0]         mem_rdata;
  logic               rd_addr;
  logic               booted;
  logic               par_sel;
  logic               ser_sel;
  logic               strobe_rise;
  logic               strobe_fall;
  logic               par_end;
  logic               ser_end;
  logic               ser_ok;
  logic               frame_end;
  logic               commit;

  function automatic logic fpc_is_read(input logic [7:0] op);
    return op == `FPC_OP_RD_LOCK || op == `FPC_OP_RD_FUSE ||
           op == `FPC_OP_RD_STAT;
  endfunction

  function automatic logic fpc_is_write(input logic [7:0] op);
    return op == `FPC_OP_WR_FUSE || op == `FPC_OP_WR_LOCK;
  endfunction

  function automatic logic fpc_is_lock(input logic [7:0] op);
    return op == `FPC_OP_RD_LOCK || op == `FPC_OP_WR_LOCK;
  endfunction

  fpc_serial_link u_link (
    .reset        (reset),
    .serial_clk   (serial_clk),
    .serial_sel_n (serial_sel_n),
    .serial_din   (serial_din),
    .tx_byte      (st_q.dout),
    .serial_dout  (serial_dout),
    .rx_byte      (rx_byte),
    .rx_tgl       (rx_tgl)
  );

  fpc_fuse_mem #(
    .W     (8),
    .DEPTH (2),
    .INIT  ({`FPC_LOCK_RESET, `FPC_FUSE_RESET})
  ) u_mem (
    .clk     (clk),
    .wr_en   (commit),
    .wr_addr (st_q.wr.addr),
    .wr_data (st_q.wr.data),
    .rd_addr (rd_addr),
    .rd_data (mem_rdata)
  );

  assign booted      = st_q.boot == 2'h2;
  assign par_sel     = ~st_q.sel_sy[1];
  assign ser_sel     = ~st_q.ss_sy[1];
  assign strobe_rise = st_q.strobe_sy[1] & ~st_q.strobe_sy[2];
  assign strobe_fall = ~st_q.strobe_sy[1] & st_q.strobe_sy[2];
  assign par_end     = st_q.sel_sy[1] & ~st_q.sel_sy[2];
  assign ser_end     = st_q.ss_sy[1] & ~st_q.ss_sy[2];
  // serial session only while enable fuse held at power-up
  assign ser_ok      = ser_sel & ~par_sel & st_q.spe_eff;
  assign frame_end   = st_q.ser ? ser_end : par_end;
  assign commit      = frame_end & st_q.wr.pending & ~st_q.busy;
  assign rd_addr     = (booted && fpc_is_lock(st_q.opcode)) ?
                       `FPC_LOCK_ADDR : `FPC_FUSE_ADDR;

  // one byte source for both links
  assign ev.valid  = booted & ((par_sel & strobe_rise) |
                     (ser_ok & (st_q.tgl_sy[1] ^ st_q.tgl_sy[2])));
  assign ev.serial = ~par_sel;
  assign ev.data   = par_sel ? st_q.data_s1 : rx_byte;

  always_comb begin
    st_d = st_q;
    st_d.strobe_sy = {st_q.strobe_sy[1:0], byte_strobe_pin};
    st_d.data_s0   = parallel_data_port_in;
    st_d.data_s1   = st_q.data_s0;
    st_d.sel_sy    = {st_q.sel_sy[1:0], select_pin_n};
    st_d.ss_sy     = {st_q.ss_sy[1:0], serial_sel_n};
    st_d.tgl_sy    = {st_q.tgl_sy[1:0], rx_tgl};

    // enable fuse is sampled once per power-up
    if (!booted) begin
      st_d.boot = st_q.boot + 2'h1;
      if (st_q.boot == 2'h1) begin
        st_d.spe_eff = mem_rdata[`FPC_SPE_BIT];
      end
    end

    if (st_q.busy) begin
      st_d.busy_cnt = st_q.busy_cnt - CW'(1);
      if (st_q.busy_cnt == CW'(1)) begin
        st_d.busy   = 1'b0;
        st_d.busy_n = 1'b1;
      end
    end

    if (frame_end) begin
      if (commit) begin
        st_d.busy     = 1'b1;
        st_d.busy_n   = 1'b0;
        // counts down to one, so busy stands exactly the write wait
        st_d.busy_cnt = CW'(WRITE_WAIT_CYC);
      end
      st_d.state      = fpc_pkg::FPC_IDLE;
      st_d.wr.pending = 1'b0;
      st_d.ser        = 1'b0;
    end else if (ev.valid) begin
      case (st_q.state)
        fpc_pkg::FPC_IDLE: begin
          st_d.ser = ev.serial;
          if (ev.data == `FPC_PREAMBLE) begin
            st_d.state = fpc_pkg::FPC_PRE;
          end else begin
            st_d.state = fpc_pkg::FPC_SKIP;
          end
        end
        fpc_pkg::FPC_PRE: begin
          st_d.opcode = ev.data;
          if (fpc_is_read(ev.data) || fpc_is_write(ev.data)) begin
            st_d.state = fpc_pkg::FPC_OPC;
          end else begin
            st_d.state = fpc_pkg::FPC_SKIP;
          end
        end
        fpc_pkg::FPC_OPC: begin
          if (ev.data == `FPC_ADDR_ZERO) begin
            st_d.state = fpc_pkg::FPC_ADH;
          end else begin
            st_d.state = fpc_pkg::FPC_SKIP;
          end
        end
        fpc_pkg::FPC_ADH: begin
          if (ev.data == `FPC_ADDR_ZERO) begin
            st_d.state = fpc_pkg::FPC_DATA;
          end else begin
            st_d.state = fpc_pkg::FPC_SKIP;
          end
        end
        fpc_pkg::FPC_DATA: begin
          st_d.state = fpc_pkg::FPC_DONE;
          // a write landing during the write wait is dropped
          if (fpc_is_write(st_q.opcode) && !st_q.busy) begin
            st_d.wr.pending = 1'b1;
            st_d.wr.addr = fpc_is_lock(st_q.opcode) ?
                           `FPC_LOCK_ADDR : `FPC_FUSE_ADDR;
            st_d.wr.data = ev.data;
            if (st_q.ser && !fpc_is_lock(st_q.opcode)) begin
              // clearing allowed, setting only over parallel
              st_d.wr.data[`FPC_SPE_BIT] = ev.data[`FPC_SPE_BIT] &
                mem_rdata[`FPC_SPE_BIT];
            end
          end
        end
        default: begin
        end
      endcase
    end

    // result byte settles long before either link shows it
    if (st_q.state == fpc_pkg::FPC_ADH) begin
      if (st_q.opcode == `FPC_OP_RD_STAT) begin
        st_d.dout = 8'h00;
        st_d.dout[`FPC_STAT_BUSY_BIT] = st_q.busy;
      end else begin
        st_d.dout = mem_rdata;
      end
    end

    if (par_sel && strobe_fall && !st_q.ser &&
        st_q.state == fpc_pkg::FPC_DATA && fpc_is_read(st_q.opcode)) begin
      st_d.drive = 1'b1;
    end
    if (!par_sel) begin
      st_d.drive = 1'b0;
    end
    st_d.p_oe_n = ~st_d.drive;

    st_d.sdout_oe_n = ~(ser_sel && st_q.ser && fpc_is_read(st_q.opcode) &&
                        (st_q.state == fpc_pkg::FPC_ADH ||
                         st_q.state == fpc_pkg::FPC_DATA ||
                         st_q.state == fpc_pkg::FPC_DONE));
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q            <= '0;
      st_q.sel_sy     <= 3'h7;
      st_q.ss_sy      <= 3'h7;
      st_q.p_oe_n     <= 1'b1;
      st_q.sdout_oe_n <= 1'b1;
      st_q.busy_n     <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign parallel_data_port_out  = st_q.dout;
  assign parallel_data_port_oe_n = st_q.p_oe_n;
  assign busy_indicator_pin_n    = st_q.busy_n;
  assign serial_dout_oe_n        = st_q.sdout_oe_n;

  sequence s_read_turn;
    st_q.state == fpc_pkg::FPC_DATA && fpc_is_read(st_q.opcode) &&
    !st_q.ser;
  endsequence

  sequence s_fourth_fall;
    par_sel && strobe_fall;
  endsequence

  property p_drive_after_fall;
    @(posedge clk) disable iff (reset)
    s_read_turn ##0 s_fourth_fall |=> !parallel_data_port_oe_n;
  endproperty
  a_drive_after_fall: assert property (p_drive_after_fall)
    else $error("data port not driven after fourth strobe");

  property p_release_on_sel;
    @(posedge clk) disable iff (reset)
    st_q.sel_sy[1] |=> parallel_data_port_oe_n;
  endproperty
  a_release_on_sel: assert property (p_release_on_sel)
    else $error("data port driven while select high");

  property p_ignore_high;
    @(posedge clk) disable iff (reset)
    st_q.sel_sy[1] && !st_q.ser && strobe_rise && !ser_ok |=>
      $stable(st_q.state) || st_q.state == fpc_pkg::FPC_IDLE;
  endproperty
  a_ignore_high: assert property (p_ignore_high)
    else $error("strobe taken while select high");

  property p_preamble;
    @(posedge clk) disable iff (reset)
    ev.valid && !frame_end && st_q.state == fpc_pkg::FPC_IDLE &&
      ev.data != `FPC_PREAMBLE |=> st_q.state == fpc_pkg::FPC_SKIP;
  endproperty
  a_preamble: assert property (p_preamble)
    else $error("bad preamble not skipped");

  property p_commit_busy;
    @(posedge clk) disable iff (reset)
    commit |=> !busy_indicator_pin_n [*2];
  endproperty
  a_commit_busy: assert property (p_commit_busy)
    else $error("write end did not raise busy");

  property p_busy_release;
    @(posedge clk) disable iff (reset)
    $rose(busy_indicator_pin_n) |-> $past(st_q.busy_cnt) == CW'(1);
  endproperty
  a_busy_release: assert property (p_busy_release)
    else $error("busy released early");

  property p_spe_hold;
    @(posedge clk) disable iff (reset)
    booted |=> $stable(st_q.spe_eff);
  endproperty
  a_spe_hold: assert property (p_spe_hold)
    else $error("enable fuse copy changed before power cycle");

  property p_ser_refuse;
    @(posedge clk) disable iff (reset)
    booted && !st_q.spe_eff && !par_sel &&
      st_q.state == fpc_pkg::FPC_IDLE |=> st_q.state == fpc_pkg::FPC_IDLE;
  endproperty
  a_ser_refuse: assert property (p_ser_refuse)
    else $error("serial byte taken with enable fuse clear");

  property p_no_serial_set;
    @(posedge clk) disable iff (reset)
    commit && st_q.ser && st_q.wr.addr == `FPC_FUSE_ADDR |->
      !(st_q.wr.data[`FPC_SPE_BIT] && !mem_rdata[`FPC_SPE_BIT]);
  endproperty
  a_no_serial_set: assert property (p_no_serial_set)
    else $error("serial write set the enable fuse");

  property p_ser_share;
    @(posedge clk) disable iff (reset)
    ev.valid && ev.serial && !frame_end &&
      st_q.state == fpc_pkg::FPC_IDLE && ev.data == `FPC_PREAMBLE |=>
      st_q.state == fpc_pkg::FPC_PRE && st_q.ser;
  endproperty
  a_ser_share: assert property (p_ser_share)
    else $error("serial preamble not accepted");

  property p_ser_oe_off;
    @(posedge clk) disable iff (reset)
    ser_end |=> serial_dout_oe_n;
  endproperty
  a_ser_oe_off: assert property (p_ser_oe_off)
    else $error("serial output driven after select rose");
endmodule
`default_nettype wire

// ---- verification/fpc_prog_model.sv ----
// Purpose: programmer model driving both programming links
// Assumes: serial clock made here, 48 ns period, only inside frames
// Notes: released lines show a toggled or changing value, never the last
`default_nettype none
module fpc_prog_model (
  input  wire logic       clk,
  input  wire logic       serial_dout,
  output var  logic       select_pin_n,
  output var  logic       byte_strobe_pin,
  output var  logic [7:0] p_data,
  output var  logic       p_drv,
  output var  logic       serial_clk,
  output var  logic       serial_sel_n,
  output var  logic       serial_din,
  output var  logic [7:0] rd_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  event rd_ev;

  initial begin
    select_pin_n    = 1'b1;
    byte_strobe_pin = 1'b0;
    p_data          = 8'h00;
    p_drv           = 1'b0;
    serial_sel_n    = 1'b1;
    serial_clk      = 1'b0;
    serial_din      = 1'b0;
    rd_byte         = 8'h00;
  end

  // sel = 0 strobes the bytes with select left high
  task automatic par_frame(input logic [39:0] f, input int n,
                           input bit rd, input bit sel);
    select_pin_n <= !sel;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      p_data <= f[39-8*i -: 8];
      p_drv  <= 1'b1;
      repeat (3) @(posedge clk);
      byte_strobe_pin <= 1'b1;
      repeat (8) @(posedge clk);
      if (rd && i == n - 1) begin
        p_drv <= 1'b0;
        @(posedge clk);
      end
      byte_strobe_pin <= 1'b0;
      repeat (6) @(posedge clk);
    end
    p_drv <= 1'b0;
    if (rd) repeat (10) @(posedge clk);
    select_pin_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  // last byte is captured from the device when rd is set
  task automatic spi_frame(input logic [39:0] f, input int n,
                           input bit rd);
    logic [7:0] b;
    @(posedge clk);
    #7;
    serial_sel_n = 1'b0;
    #200;
    for (int i = 0; i < n; i++) begin
      b = f[39-8*i -: 8];
      for (int k = 7; k >= 0; k--) begin
        serial_din = b[k];
        #24 serial_clk = 1'b1;
        if (rd && i == n - 1) rd_byte[k] = serial_dout;
        #24 serial_clk = 0;
      end
      // clock stands low between bytes to give the core time
      #200;
    end
    if (rd) ->rd_ev;
    serial_din   = ~serial_din;
    serial_sel_n = 1'b1;
    #200;
  endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Purpose: self-checking bench of the programming command port
// Assumes: short write wait parameter, fuse cells start at ff
// Notes: a power cycle is modelled by a reset pulse
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned WAIT = 400;
  logic        clk;
  logic        reset;
  logic        select_pin_n;
  logic        byte_strobe_pin;
  logic [7:0]  p_data;
  logic        p_drv;
  logic [7:0]  port_in;
  logic [7:0]  port_out;
  logic        port_oe_n;
  logic        busy_n;
  logic        serial_clk;
  logic        serial_sel_n;
  logic        serial_din;
  logic        serial_dout;
  logic        sdout_oe_n;
  logic [7:0]  pat_q;
  logic [7:0]  rd_byte;
  logic        sd_on_q;
  int          fails;
  int          n_tests;
  int          cyc;
  int          bcnt;
  int          blen;
  logic [7:0]  pq[$];
  logic [7:0]  sq[$];
  logic [7:0]  fuse_d;
  logic [7:0]  lock_d;
  logic [7:0]  ops[3];
  logic [7:0]  exp3[3];

  // a released port shows a value that changes every cycle
  assign port_in = !port_oe_n ? port_out : (p_drv ? p_data : pat_q);

  fpc_top #(.WRITE_WAIT_CYC(WAIT)) DUT (
    .clk                     (clk),
    .reset                   (reset),
    .select_pin_n            (select_pin_n),
    .byte_strobe_pin         (byte_strobe_pin),
    .parallel_data_port_in   (port_in),
    .parallel_data_port_out  (port_out),
    .parallel_data_port_oe_n (port_oe_n),
    .busy_indicator_pin_n    (busy_n),
    .serial_clk              (serial_clk),
    .serial_sel_n            (serial_sel_n),
    .serial_din              (serial_din),
    .serial_dout             (serial_dout),
    .serial_dout_oe_n        (sdout_oe_n)
  );

  fpc_prog_model u_prog (
    .clk             (clk),
    .serial_dout     (sdout_oe_n ? pat_q[0] : serial_dout),
    .select_pin_n    (select_pin_n),
    .byte_strobe_pin (byte_strobe_pin),
    .p_data          (p_data),
    .p_drv           (p_drv),
    .serial_clk      (serial_clk),
    .serial_sel_n    (serial_sel_n),
    .serial_din      (serial_din),
    .rd_byte         (rd_byte)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    pat_q <= pat_q + 8'h3b;
    if (sdout_oe_n === 1'b0) sd_on_q <= 1'b1;
    if (busy_n === 1'b0) begin
      bcnt <= bcnt + 1;
    end else if (bcnt != 0) begin
      blen <= bcnt;
      bcnt <= 0;
    end
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      $display("ERROR timeout expected done seen hang");
      results();
    end
  end

  task automatic pcmd(input logic [7:0] op, input logic [7:0] d,
                      input bit rd);
    u_prog.par_frame({8'haa, op, 16'h0000, d}, rd ? 4 : 5, rd, 1'b1);
  endtask

  task automatic scmd(input logic [7:0] op, input logic [7:0] d,
                      input bit rd);
    u_prog.spi_frame({8'haa, op, 16'h0000, d}, 5, rd);
  endtask

  // bounded wait for one whole write cycle, length measured exactly
  task automatic wait_busy();
    int t;
    t    = 0;
    blen = 0;
    while (busy_n !== 1'b0 && t < 300) begin
      @(posedge clk);
      t++;
    end
    while (busy_n !== 1'b1 && t < WAIT + 400) begin
      @(posedge clk);
      t++;
    end
    repeat (4) @(posedge clk);
    check("busy_len", blen, WAIT);
  endtask

  // links idle with selects high while reset stands
  task automatic do_reset();
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // result watchers: oldest note against what appears
  initial begin
    fork
      forever begin
        @(negedge port_oe_n);
        @(posedge clk);
        #1;
        if (pq.size() == 0) check("par_unexpected", 1, 0);
        else check("par_data", port_out, pq.pop_front());
      end
      forever begin
        @(u_prog.rd_ev);
        if (sq.size() == 0) check("ser_unexpected", 1, 0);
        else check("ser_data", rd_byte, sq.pop_front());
      end
      forever begin
        @(negedge busy_n);
        check("frame_end", {select_pin_n, serial_sel_n}, 2'b11);
      end
    join
  end

  initial begin
    reset   = 1'b1;
    pat_q   = 8'h00;
    sd_on_q = 1'b0;
    fails   = 0;
    n_tests = 0;
    cyc     = 0;
    bcnt    = 0;
    blen    = 0;
    fuse_d  = 8'($urandom(32'ha2504892));
    do_reset();
    check("idle", {port_oe_n, busy_n, sdout_oe_n}, 3'b111);
    ops  = '{8'h64, 8'h61, 8'h60};
    exp3 = '{8'hff, 8'hff, 8'h00};
    for (int i = 0; i < 3; i++) begin
      pq.push_back(exp3[i]);
      pcmd(ops[i], 8'h00, 1'b1);
    end
    u_prog.par_frame(40'haa61000000, 4, 1'b1, 1'b0);
    u_prog.par_frame(40'h5561000000, 4, 1'b1, 1'b1);
    // unknown implemented set: enable bit kept, others random
    fuse_d = 8'($urandom()) | 8'h01;
    lock_d = 8'($urandom());
    pcmd(8'he1, fuse_d, 1'b0);
    pq.push_back(8'h01);
    pcmd(8'h60, 8'h00, 1'b1);
    wait_busy();
    pcmd(8'he4, lock_d, 1'b0);
    wait_busy();
    exp3 = '{lock_d, fuse_d, 8'h00};
    for (int i = 0; i < 3; i++) begin
      sq.push_back(exp3[i]);
      scmd(ops[i], 8'h00, 1'b1);
    end
    scmd(8'he1, fuse_d & 8'hfe, 1'b0);
    wait_busy();
    sq.push_back(fuse_d & 8'hfe);
    scmd(8'h61, 8'h00, 1'b1);
    scmd(8'he1, fuse_d, 1'b0);
    wait_busy();
    pq.push_back(fuse_d & 8'hfe);
    pcmd(8'h61, 8'h00, 1'b1);
    do_reset();
    sd_on_q = 1'b0;
    scmd(8'he1, 8'hff, 1'b0);
    repeat (20) @(posedge clk);
    check("refused", {sd_on_q, busy_n}, 2'b01);
    pcmd(8'he1, 8'hff, 1'b0);
    wait_busy();
    do_reset();
    sq.push_back(8'hff);
    scmd(8'h61, 8'h00, 1'b1);
    repeat (20) @(posedge clk);
    check("queues", pq.size() + sq.size(), 0);
    results();
  end
endmodule
`default_nettype wire
